// ---- rtl/pkm_defs.svh ----
// register offsets, field positions, reset values and timing counts
// assumes a 20 MHz core clock; included by its bare name
`ifndef PKM_DEFS_SVH
`define PKM_DEFS_SVH

`define PKM_ADDR_W          9
`define PKM_OFF_KEY_TIMING  9'h10F
`define PKM_OFF_PULL_LO     9'h110
`define PKM_OFF_PULL_HI     9'h111
`define PKM_OFF_OSC_TRIM    9'h112
`define PKM_OFF_RSVD        9'h113
`define PKM_OFF_MON_CTRL    9'h114
`define PKM_OFF_OFF_EN      9'h130
`define PKM_OFF_IRQ_STAT    9'h131
`define PKM_OFF_IRQ_CLR     9'h132
`define PKM_OFF_IRQ_EN      9'h133

`define PKM_KEY_DELAY_LSB   0
`define PKM_SHUT_DELAY_LSB  2
`define PKM_OSC_TRIM_LSB    4
`define PKM_MONITOR_OPERATING_MODE_LSB    4
`define PKM_START_DLY_LSB   6
`define PKM_EN_KEY_OFF      0
`define PKM_EN_PAIRED_OFF   1
`define PKM_EV_RANGE        0
`define PKM_EV_LOCK         1
`define PKM_EV_KEY_OFF      2
`define PKM_EV_PAIRED_OFF   3
`define PKM_EV_N            4

`define PKM_RST_KEY_TIMING  8'h0A
`define PKM_RST_ZERO        8'h00

`define PKM_CLK_PERIOD_NS   50
`define PKM_MS_NS           32'h000F_4240
`define PKM_MS_CYCLES       (`PKM_MS_NS / `PKM_CLK_PERIOD_NS)

// press thresholds in milliseconds
`define PKM_LOCK_MS_0       16'h03E8
`define PKM_LOCK_MS_1       16'h05DC
`define PKM_LOCK_MS_2       16'h07D0
`define PKM_LOCK_MS_3       16'h1B58
`define PKM_SHUT_MS_0       16'h0000
`define PKM_SHUT_MS_1       16'h0FA0
`define PKM_SHUT_MS_2       16'h1388
`define PKM_SHUT_MS_3       16'h1770

// measurements to skip before range comparison
`define PKM_DLY_MEAS_0      3'h0
`define PKM_DLY_MEAS_1      3'h1
`define PKM_DLY_MEAS_2      3'h2
`define PKM_DLY_MEAS_3      3'h4

`endif

// ---- rtl/pkm_pkg.sv ----
// types shared by the key, pull and monitor configuration block
// assumes nothing beyond a SystemVerilog compiler
package pkm_pkg;

   typedef enum logic [1:0] {
      PKM_MODE_LOCKOUT = 2'b00,
      PKM_MODE_AUTO    = 2'b01,
      PKM_MODE_BURST   = 2'b10,
      PKM_MODE_RSVD    = 2'b11
   } pkm_monitor_operating_mode_t;

   typedef enum logic [2:0] {
      PKM_MS_OFF   = 3'b001,
      PKM_MS_DELAY = 3'b010,
      PKM_MS_ARMED = 3'b100
   } pkm_mon_state_t;

endpackage : pkm_pkg

// ---- rtl/pkm_press_timer.sv ----
// saturating press timer: counts millisecond ticks while a press is held
// assumes ms_tick is a one-cycle pulse from a divider on mclk
`timescale 1ns/1ps
module pkm_press_timer #(
   parameter int TW = 16
) (
   input  wire logic          mclk,
   input  wire logic          sys_rst,
   input  wire logic          ms_tick,
   input  wire logic          pressed,
   input  wire logic [TW-1:0] threshold,
   output logic               reached
);

   logic [TW-1:0] count_reg;
   logic [TW-1:0] count_next;
   logic          reached_next;

   always_comb begin
      count_next = count_reg;
      if (!pressed) begin
         count_next = '0;
      end else if (ms_tick && (count_reg != {TW{1'b1}})) begin
         count_next = count_reg + 1'b1;
      end
      // compared every cycle, so a rewritten threshold applies at once
      reached_next = pressed && (count_next >= threshold);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         count_reg <= '0;
         reached   <= 1'b0;
      end else begin
         count_reg <= count_next;
         reached   <= reached_next;
      end
   end

   property p_release_clears;
      @(posedge mclk) disable iff (sys_rst)
      !pressed |=> (count_reg == '0) && !reached;
   endproperty
   a_release_clears: assert property (p_release_clears) else $error("press timer not cleared on release");

   property p_reached_cause;
      @(posedge mclk) disable iff (sys_rst)
      $rose(reached) |-> $past(pressed) && (count_reg >= $past(threshold));
   endproperty
   a_reached_cause: assert property (p_reached_cause) else $error("threshold reached without enough press");

endmodule : pkm_press_timer

// ---- rtl/pkm_range_monitor.sv ----
// regulator output monitor: start delay and event/shutdown per operating mode
// assumes meas_done, third_slot_done are one-cycle pulses from the measurement sequencer
`timescale 1ns/1ps
`include "pkm_defs.svh"
module pkm_range_monitor (
   input  wire logic                  mclk,
   input  wire logic                  sys_rst,
   input  wire logic                  regulator_on,
   input  wire logic                  meas_done,
   input  wire logic                  third_slot_done,
   input  wire logic                  out_of_range,
   input  wire logic [1:0]            start_delay,
   input  pkm_pkg::pkm_monitor_operating_mode_t     mode,
   output logic                       fault_pulse,
   output logic                       regulator_off
);

   pkm_pkg::pkm_mon_state_t state_reg;
   pkm_pkg::pkm_mon_state_t state_next;
   logic [2:0]              dcnt_reg;
   logic [2:0]              dcnt_next;
   logic [2:0]              need;
   logic                    fault_next;
   logic                    off_next;
   logic                    lockout_hit;

   always_comb begin
      unique case (start_delay)
         2'b00:   need = `PKM_DLY_MEAS_0;
         2'b01:   need = `PKM_DLY_MEAS_1;
         2'b10:   need = `PKM_DLY_MEAS_2;
         default: need = `PKM_DLY_MEAS_3;
      endcase
      state_next = state_reg;
      dcnt_next  = dcnt_reg;
      unique case (state_reg)
         pkm_pkg::PKM_MS_OFF: begin
            dcnt_next = need;
            if (regulator_on) begin
               state_next = (need == 3'h0) ? pkm_pkg::PKM_MS_ARMED : pkm_pkg::PKM_MS_DELAY;
            end
         end
         pkm_pkg::PKM_MS_DELAY: begin
            if (meas_done) begin
               dcnt_next = dcnt_reg - 3'h1;
               if (dcnt_reg == 3'h1) begin
                  state_next = pkm_pkg::PKM_MS_ARMED;
               end
            end
         end
         pkm_pkg::PKM_MS_ARMED: begin
         end
         default: state_next = pkm_pkg::PKM_MS_OFF;
      endcase
      if (!regulator_on) begin
         state_next = pkm_pkg::PKM_MS_OFF;
      end
      lockout_hit = regulator_on && (state_reg == pkm_pkg::PKM_MS_ARMED) && meas_done && out_of_range;
      unique case (mode)
         pkm_pkg::PKM_MODE_LOCKOUT: fault_next = lockout_hit;
         pkm_pkg::PKM_MODE_AUTO:    fault_next = meas_done;
         pkm_pkg::PKM_MODE_BURST:   fault_next = third_slot_done;
         default:                   fault_next = 1'b0;
      endcase
      // the regulator stays off until software or the sequencer drops its enable
      off_next = regulator_on && (regulator_off ||
                 ((mode == pkm_pkg::PKM_MODE_LOCKOUT) && lockout_hit));
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_reg     <= pkm_pkg::PKM_MS_OFF;
         dcnt_reg      <= 3'h0;
         fault_pulse   <= 1'b0;
         regulator_off <= 1'b0;
      end else begin
         state_reg     <= state_next;
         dcnt_reg      <= dcnt_next;
         fault_pulse   <= fault_next;
         regulator_off <= off_next;
      end
   end

   property p_lockout_off;
      @(posedge mclk) disable iff (sys_rst)
      (mode == pkm_pkg::PKM_MODE_LOCKOUT) && lockout_hit |=> regulator_off && fault_pulse;
   endproperty
   a_lockout_off: assert property (p_lockout_off) else $error("lockout fault did not shut regulator");

   property p_auto_event;
      @(posedge mclk) disable iff (sys_rst)
      (mode == pkm_pkg::PKM_MODE_AUTO) && meas_done |=> fault_pulse;
   endproperty
   a_auto_event: assert property (p_auto_event) else $error("auto measurement gave no event");

   property p_burst_quiet;
      @(posedge mclk) disable iff (sys_rst)
      (mode == pkm_pkg::PKM_MODE_BURST) && !third_slot_done |=> !fault_pulse && !regulator_off;
   endproperty
   a_burst_quiet: assert property (p_burst_quiet) else $error("burst event outside third slot");

   property p_delay_blocks;
      @(posedge mclk) disable iff (sys_rst)
      (state_reg != pkm_pkg::PKM_MS_ARMED) && (mode == pkm_pkg::PKM_MODE_LOCKOUT) |=> !fault_pulse;
   endproperty
   a_delay_blocks: assert property (p_delay_blocks) else $error("range compared before start delay");

endmodule : pkm_range_monitor

// ---- rtl/pkm_top.sv ----
// configuration slice: key press timing, pin pulls, oscillator trim, regulator monitor
// assumes a byte register port on mclk with read data one cycle after the read strobe
//
// What this block does
// - the shutdown press threshold is the lock time plus 0, 4, 5 or 6 s chosen by a two-bit field.
// - the key lock asserts after a held press of 1, 1.5, 2 or 7 s chosen by a two-bit field.
// - sixteen pull bits, pins 0-7 in the low register and 8-15 in the next, enable input pull-downs.
// - on an open-drain output a set pull bit enables the pull-up on the pin's selected rail.
// - a signed four-bit trim in bits 7:4 offsets the fast oscillator in 1.33 percent steps.
// - range comparison starts at once or after one, two or four measurements after enable.
// - mode 01 raises the range event and interrupt on every finished automatic measurement.
// - mode 10 raises the event only after the third channel slot; mode 11 raises nothing.
// - long-press key shutdown happens only while the key shutdown enable is set.
// - paired-pin shutdown happens only while the paired-pin shutdown enable is set.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "pkm_defs.svh"
module pkm_top #(
   parameter int MS_CYCLES = `PKM_MS_CYCLES
) (
   input  wire logic                   mclk,
   input  wire logic                   sys_rst,
   input  wire logic [`PKM_ADDR_W-1:0] reg_addr,
   input  wire logic [7:0]             reg_wr_data,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [7:0]             reg_rd_data,
   input  wire logic                   power_key_pin,
   input  wire logic                   paired_pin_a,
   input  wire logic                   paired_pin_b,
   input  wire logic [15:0]            pin_is_open_drain,
   input  wire logic [15:0]            pin_type_rail_select,
   input  wire logic                   regulator_on,
   input  wire logic                   meas_done,
   input  wire logic                   third_slot_done,
   input  wire logic                   out_of_range,
   output logic                        power_key_locked,
   output logic                        key_off_req,
   output logic                        paired_off_req,
   output logic      [15:0]            pin_pulldown_en,
   output logic      [15:0]            pin_pullup_en,
   output logic      [15:0]            pin_pullup_rail,
   output logic      [3:0]             hf_osc_trim,
   output logic                        regulator_off_req,
   output logic                        interrupt_out_n
);

   localparam int DW = $clog2(MS_CYCLES);

   // decode of the press threshold fields, shared by lock and shutdown timers
   function automatic logic [15:0] lock_ms(input logic [1:0] code);
      unique case (code)
         2'b00:   lock_ms = `PKM_LOCK_MS_0;
         2'b01:   lock_ms = `PKM_LOCK_MS_1;
         2'b10:   lock_ms = `PKM_LOCK_MS_2;
         default: lock_ms = `PKM_LOCK_MS_3;
      endcase
   endfunction : lock_ms

   function automatic logic [15:0] shut_ms(input logic [1:0] code);
      unique case (code)
         2'b00:   shut_ms = `PKM_SHUT_MS_0;
         2'b01:   shut_ms = `PKM_SHUT_MS_1;
         2'b10:   shut_ms = `PKM_SHUT_MS_2;
         default: shut_ms = `PKM_SHUT_MS_3;
      endcase
   endfunction : shut_ms

   // ---------------- register file
   logic [7:0]            key_timing_reg;
   logic [7:0]            key_timing_next;
   logic [7:0]            pull_lo_reg;
   logic [7:0]            pull_lo_next;
   logic [7:0]            pull_hi_reg;
   logic [7:0]            pull_hi_next;
   logic [3:0]            osc_trim_reg;
   logic [3:0]            osc_trim_next;
   logic [7:0]            rsvd_reg;
   logic [7:0]            rsvd_next;
   logic [7:0]            mon_ctrl_reg;
   logic [7:0]            mon_ctrl_next;
   logic [1:0]            off_en_reg;
   logic [1:0]            off_en_next;
   logic [`PKM_EV_N-1:0]  irq_en_reg;
   logic [`PKM_EV_N-1:0]  irq_en_next;
   logic [`PKM_EV_N-1:0]  irq_stat_reg;
   logic [`PKM_EV_N-1:0]  irq_stat_next;
   logic [`PKM_EV_N-1:0]  irq_clr;
   logic [`PKM_EV_N-1:0]  events;
   logic [7:0]            rd_mux;
   logic [7:0]            rd_data_next;

   always_comb begin
      key_timing_next = key_timing_reg;
      pull_lo_next    = pull_lo_reg;
      pull_hi_next    = pull_hi_reg;
      osc_trim_next   = osc_trim_reg;
      rsvd_next       = rsvd_reg;
      mon_ctrl_next   = mon_ctrl_reg;
      off_en_next     = off_en_reg;
      irq_en_next     = irq_en_reg;
      irq_clr         = '0;
      if (reg_wr) begin
         unique case (reg_addr)
            `PKM_OFF_KEY_TIMING: key_timing_next = reg_wr_data;
            `PKM_OFF_PULL_LO:    pull_lo_next    = reg_wr_data;
            `PKM_OFF_PULL_HI:    pull_hi_next    = reg_wr_data;
            `PKM_OFF_OSC_TRIM:   osc_trim_next   = reg_wr_data[`PKM_OSC_TRIM_LSB +: 4];
            `PKM_OFF_RSVD:       rsvd_next       = reg_wr_data;
            `PKM_OFF_MON_CTRL:   mon_ctrl_next   = reg_wr_data;
            `PKM_OFF_OFF_EN:     off_en_next     = reg_wr_data[1:0];
            `PKM_OFF_IRQ_CLR:    irq_clr         = reg_wr_data[`PKM_EV_N-1:0];
            `PKM_OFF_IRQ_EN:     irq_en_next     = reg_wr_data[`PKM_EV_N-1:0];
            default: ;
         endcase
      end
      rd_mux = 8'h00;
      unique case (reg_addr)
         `PKM_OFF_KEY_TIMING: rd_mux = key_timing_reg;
         `PKM_OFF_PULL_LO:    rd_mux = pull_lo_reg;
         `PKM_OFF_PULL_HI:    rd_mux = pull_hi_reg;
         `PKM_OFF_OSC_TRIM:   rd_mux = {osc_trim_reg, 4'h0};
         `PKM_OFF_RSVD:       rd_mux = rsvd_reg;
         `PKM_OFF_MON_CTRL:   rd_mux = mon_ctrl_reg;
         `PKM_OFF_OFF_EN:     rd_mux = {6'h00, off_en_reg};
         `PKM_OFF_IRQ_STAT:   rd_mux = {4'h0, irq_stat_reg};
         `PKM_OFF_IRQ_EN:     rd_mux = {4'h0, irq_en_reg};
         default:             rd_mux = 8'h00;
      endcase
      // read data is valid only in the cycle after the strobe
      rd_data_next = reg_rd ? rd_mux : 8'h00;
      // a new event outranks a clear written in the same cycle
      irq_stat_next = (irq_stat_reg & ~irq_clr) | events;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         key_timing_reg <= `PKM_RST_KEY_TIMING;
         pull_lo_reg    <= `PKM_RST_ZERO;
         pull_hi_reg    <= `PKM_RST_ZERO;
         osc_trim_reg   <= 4'h0;
         rsvd_reg       <= `PKM_RST_ZERO;
         mon_ctrl_reg   <= `PKM_RST_ZERO;
         off_en_reg     <= 2'h0;
         irq_en_reg     <= '0;
         irq_stat_reg   <= '0;
         reg_rd_data    <= 8'h00;
      end else begin
         key_timing_reg <= key_timing_next;
         pull_lo_reg    <= pull_lo_next;
         pull_hi_reg    <= pull_hi_next;
         osc_trim_reg   <= osc_trim_next;
         rsvd_reg       <= rsvd_next;
         mon_ctrl_reg   <= mon_ctrl_next;
         off_en_reg     <= off_en_next;
         irq_en_reg     <= irq_en_next;
         irq_stat_reg   <= irq_stat_next;
         reg_rd_data    <= rd_data_next;
      end
   end

   // ---------------- millisecond divider
   logic [DW-1:0] div_reg;
   logic [DW-1:0] div_next;
   logic          ms_tick_reg;
   logic          ms_tick_next;

   always_comb begin
      ms_tick_next = (div_reg == DW'(MS_CYCLES - 1));
      div_next     = ms_tick_next ? '0 : div_reg + 1'b1;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         div_reg     <= '0;
         ms_tick_reg <= 1'b0;
      end else begin
         div_reg     <= div_next;
         ms_tick_reg <= ms_tick_next;
      end
   end

   // ---------------- press timers
   logic [15:0] lock_thr;
   logic [15:0] off_thr;
   logic        key_pressed;
   logic        pair_pressed;
   logic        lock_hit;
   logic        key_off_hit;
   logic        pair_off_hit;

   always_comb begin
      lock_thr     = lock_ms(key_timing_reg[`PKM_KEY_DELAY_LSB +: 2]);
      off_thr      = 16'(lock_thr + shut_ms(key_timing_reg[`PKM_SHUT_DELAY_LSB +: 2]));
      key_pressed  = !power_key_pin;
      pair_pressed = paired_pin_a && paired_pin_b;
   end

   pkm_press_timer #(.TW(16)) u_lock_timer (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .ms_tick   (ms_tick_reg),
      .pressed   (key_pressed),
      .threshold (lock_thr),
      .reached   (lock_hit)
   );

   pkm_press_timer #(.TW(16)) u_key_off_timer (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .ms_tick   (ms_tick_reg),
      .pressed   (key_pressed),
      .threshold (off_thr),
      .reached   (key_off_hit)
   );

   pkm_press_timer #(.TW(16)) u_pair_off_timer (
      .mclk      (mclk),
      .sys_rst   (sys_rst),
      .ms_tick   (ms_tick_reg),
      .pressed   (pair_pressed),
      .threshold (off_thr),
      .reached   (pair_off_hit)
   );

   // ---------------- monitor
   logic mon_fault;
   logic mon_off;

   pkm_range_monitor u_monitor (
      .mclk            (mclk),
      .sys_rst         (sys_rst),
      .regulator_on    (regulator_on),
      .meas_done       (meas_done),
      .third_slot_done (third_slot_done),
      .out_of_range    (out_of_range),
      .start_delay     (mon_ctrl_reg[`PKM_START_DLY_LSB +: 2]),
      .mode            (pkm_pkg::pkm_monitor_operating_mode_t'(mon_ctrl_reg[`PKM_MONITOR_OPERATING_MODE_LSB +: 2])),
      .fault_pulse     (mon_fault),
      .regulator_off   (mon_off)
   );

   // ---------------- outputs
   logic        locked_next;
   logic        key_off_next;
   logic        pair_off_next;
   logic [15:0] pulldown_next;
   logic [15:0] pullup_next;
   logic        irq_n_next;

   always_comb begin
      locked_next   = lock_hit;
      key_off_next  = key_off_hit && off_en_reg[`PKM_EN_KEY_OFF];
      pair_off_next = pair_off_hit && off_en_reg[`PKM_EN_PAIRED_OFF];
      pulldown_next = {pull_hi_reg, pull_lo_reg} & ~pin_is_open_drain;
      pullup_next   = {pull_hi_reg, pull_lo_reg} & pin_is_open_drain;
      events                      = '0;
      events[`PKM_EV_RANGE]       = mon_fault;
      events[`PKM_EV_LOCK]        = locked_next && !power_key_locked;
      events[`PKM_EV_KEY_OFF]     = key_off_next && !key_off_req;
      events[`PKM_EV_PAIRED_OFF]  = pair_off_next && !paired_off_req;
      irq_n_next = ~|(irq_stat_reg & irq_en_reg);
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         power_key_locked  <= 1'b0;
         key_off_req       <= 1'b0;
         paired_off_req    <= 1'b0;
         pin_pulldown_en   <= 16'h0000;
         pin_pullup_en     <= 16'h0000;
         pin_pullup_rail   <= 16'h0000;
         hf_osc_trim       <= 4'h0;
         regulator_off_req <= 1'b0;
         interrupt_out_n   <= 1'b1;
      end else begin
         power_key_locked  <= locked_next;
         key_off_req       <= key_off_next;
         paired_off_req    <= pair_off_next;
         pin_pulldown_en   <= pulldown_next;
         pin_pullup_en     <= pullup_next;
         pin_pullup_rail   <= pin_type_rail_select;
         hf_osc_trim       <= osc_trim_reg;
         regulator_off_req <= mon_off;
         interrupt_out_n   <= irq_n_next;
      end
   end

   property p_key_off_gate;
      @(posedge mclk) disable iff (sys_rst)
      !off_en_reg[`PKM_EN_KEY_OFF] |=> !key_off_req;
   endproperty
   a_key_off_gate: assert property (p_key_off_gate) else $error("key shutdown while disabled");

   property p_pair_off_gate;
      @(posedge mclk) disable iff (sys_rst)
      (!off_en_reg[`PKM_EN_PAIRED_OFF] |=> !paired_off_req) and
      (!(paired_pin_a && paired_pin_b) |=> ##1 !paired_off_req);
   endproperty
   a_pair_off_gate: assert property (p_pair_off_gate) else $error("paired shutdown without cause");

   property p_pull_split;
      @(posedge mclk) disable iff (sys_rst)
      ##1 (pin_pulldown_en & pin_pullup_en) == 16'h0000 &&
      (pin_pulldown_en | pin_pullup_en) == $past({pull_hi_reg, pull_lo_reg});
   endproperty
   a_pull_split: assert property (p_pull_split) else $error("pull enables disagree with pull bits");

   property p_irq_level;
      @(posedge mclk) disable iff (sys_rst)
      mon_fault && irq_en_reg[`PKM_EV_RANGE] && !irq_clr[`PKM_EV_RANGE] &&
      !(reg_wr && (reg_addr == `PKM_OFF_IRQ_EN)) |=> ##1 !interrupt_out_n;
   endproperty
   a_irq_level: assert property (p_irq_level) else $error("range event did not raise interrupt");

   property p_rd_window;
      @(posedge mclk) disable iff (sys_rst)
      !reg_rd |=> reg_rd_data == 8'h00;
   endproperty
   a_rd_window: assert property (p_rd_window) else $error("read data outside its cycle");

endmodule : pkm_top

// ---- testbench/pmic_key_pull_monitor_config_tb_top.sv ----
// self-checking bench for pkm_top: register map, pulls, trim, key timers, monitor modes
// assumes pkm_top with MS_CYCLES=4, so one press millisecond is four mclk cycles
`timescale 1ns/1ps
module pmic_key_pull_monitor_config_tb_top;
   logic        mclk, sys_rst, reg_wr, reg_rd, power_key_pin, paired_pin_a, paired_pin_b;
   logic [8:0]  reg_addr;
   logic [7:0]  reg_wr_data, reg_rd_data, r;
   logic [15:0] od, rail, pdn, pup, prl;
   logic        regulator_on, meas_done, third_slot_done, out_of_range;
   logic        locked, key_off, paired_off, reg_off, irq_n;
   logic [3:0]  trim;
   logic [7:0]  mdl [0:511];
   int          fail_count, total_checks, cyc;
   int          skip [4] = '{0, 1, 2, 4};

   pkm_top #(.MS_CYCLES(4)) dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wr_data(reg_wr_data), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rd_data(reg_rd_data),
      .power_key_pin(power_key_pin), .paired_pin_a(paired_pin_a), .paired_pin_b(paired_pin_b),
      .pin_is_open_drain(od), .pin_type_rail_select(rail), .regulator_on(regulator_on),
      .meas_done(meas_done), .third_slot_done(third_slot_done), .out_of_range(out_of_range),
      .power_key_locked(locked), .key_off_req(key_off), .paired_off_req(paired_off),
      .pin_pulldown_en(pdn), .pin_pullup_en(pup), .pin_pullup_rail(prl), .hf_osc_trim(trim),
      .regulator_off_req(reg_off), .interrupt_out_n(irq_n));

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end

   task close_out;
      if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out

   task chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task wt(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : wt

   // the model keeps what software can read back, except whole bytes for 9'h130 and 9'h133; trim low nibble is not stored
   task wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wr_data <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      if (a inside {9'h10F, 9'h110, 9'h111, 9'h113, 9'h114, 9'h130, 9'h133}) mdl[a] = d;
      if (a == 9'h112) mdl[a] = d & 8'hF0;
   endtask : wr

   task rd(input logic [8:0] a, input logic [7:0] e);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 chk(reg_rd_data, e);
   endtask : rd

   task mp(input logic m, input logic t, input logic o);
      @(posedge mclk);
      meas_done <= m;
      third_slot_done <= t;
      out_of_range <= o;
      @(posedge mclk);
      meas_done <= 1'b0;
      third_slot_done <= 1'b0;
      wt(4);
   endtask : mp

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         fail_count++;
         close_out;
      end
   end

   initial begin
      {sys_rst, power_key_pin} = 2'b11;
      {reg_wr, reg_rd, paired_pin_a, paired_pin_b, regulator_on, meas_done} = '0;
      {third_slot_done, out_of_range, reg_addr, reg_wr_data, od, rail} = '0;
      foreach (mdl[i]) mdl[i] = 8'h00;
      mdl[9'h10F] = 8'h0A;
      void'($urandom(8206));
      wt(12);
      sys_rst <= 1'b0;
      wt(1);
      for (int a = 9'h10F; a <= 9'h114; a++) rd(9'(a), mdl[a]);
      od <= 16'($urandom);
      rail <= 16'($urandom);
      for (int a = 9'h110; a <= 9'h113; a++) wr(9'(a), 8'($urandom));
      wr(9'h100, 8'($urandom));
      wt(2);
      chk(pdn, {mdl[9'h111], mdl[9'h110]} & ~od);
      chk(pup, {mdl[9'h111], mdl[9'h110]} & od);
      chk(prl, rail);
      chk(trim, mdl[9'h112][7:4]);
      for (int a = 9'h110; a <= 9'h113; a++) rd(9'(a), mdl[a]);
      rd(9'h100, 8'h00);
      // lock after 1 s, shutdown after 1 s + 4 s; only the key shutdown enabled
      wr(9'h10F, 8'h04);
      wr(9'h130, 8'h01);
      wr(9'h133, 8'h02);
      @(posedge mclk);
      {power_key_pin, paired_pin_a, paired_pin_b} <= 3'b011;
      wt(3990);
      chk(locked, 1'b0);
      wt(20);
      chk(locked, 1'b1);
      chk(irq_n, 1'b0);
      wt(15980);
      chk({key_off, paired_off}, 2'b00);
      wt(20);
      chk({key_off, paired_off}, 2'b10);
      wr(9'h130, 8'h02);
      wt(3);
      chk({key_off, paired_off}, 2'b01);
      wr(9'h132, 8'h02);
      wt(3);
      chk(irq_n, 1'b1);
      rd(9'h131, 8'h0C);
      {power_key_pin, paired_pin_a, paired_pin_b} <= 3'b100;
      wr(9'h132, 8'hFF);
      // lockout mode: comparison starts after 0, 1, 2 or 4 measurements
      for (int d = 0; d < 4; d++) begin
         wr(9'h114, 8'(d << 6));
         @(posedge mclk);
         regulator_on <= 1'b1;
         for (int k = 0; k < skip[d]; k++) mp(1'b1, 1'b0, 1'b1);
         chk(reg_off, 1'b0);
         mp(1'b1, 1'b0, 1'b1);
         chk(reg_off, 1'b1);
         rd(9'h131, 8'h01);
         wr(9'h132, 8'h01);
         @(posedge mclk);
         regulator_on <= 1'b0;
         wt(3);
      end
      for (int m = 1; m < 4; m++) begin
         wr(9'h114, 8'(m << 4));
         mp(1'b1, 1'b0, 1'b1);
         rd(9'h131, 8'(m == 1));
         wr(9'h132, 8'h01);
         mp(1'b0, 1'b1, 1'b1);
         rd(9'h131, 8'(m == 2));
         wr(9'h132, 8'h01);
      end
      // lock threshold lowered under a running press: the new value applies at once
      wr(9'h10F, 8'h03);
      power_key_pin <= 1'b0;
      wt(4100);
      chk(locked, 1'b0);
      wr(9'h10F, 8'h00);
      wt(3);
      chk(locked, 1'b1);
      power_key_pin <= 1'b1;
      close_out;
   end
endmodule : pmic_key_pull_monitor_config_tb_top
